// >>> cmd_delay.sv
`timescale 1ns/1ns
`default_nettype none
// Holds a posted command for the additive latency before release.
module cmd_delay (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [2:0] al_i,
  output logic rd_o,
  output logic wr_o
);
  logic [emr_pkg::AL_DEPTH-1:0] rd_pipe;
  logic [emr_pkg::AL_DEPTH-1:0] wr_pipe;
  logic [emr_pkg::AL_DEPTH-1:0] next_rd_pipe;
  logic [emr_pkg::AL_DEPTH-1:0] next_wr_pipe;
  logic next_rd;
  logic next_wr;

  always_comb begin
    next_rd_pipe = {rd_pipe[emr_pkg::AL_DEPTH-2:0], rd_i};
    next_wr_pipe = {wr_pipe[emr_pkg::AL_DEPTH-2:0], wr_i};
    next_rd = (al_i == 3'h0) ? rd_i : rd_pipe[al_i - 3'h1];
    next_wr = (al_i == 3'h0) ? wr_i : wr_pipe[al_i - 3'h1];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_pipe <= '0;
      wr_pipe <= '0;
      rd_o <= 1'b0;
      wr_o <= 1'b0;
    end else begin
      rd_pipe <= next_rd_pipe;
      wr_pipe <= next_wr_pipe;
      rd_o <= next_rd;
      wr_o <= next_wr;
    end
  end
endmodule : cmd_delay
`default_nettype wire

// >>> ddr2_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module ddr2_ctrl_model (
  // Clock
  input wire logic clk_i,
  // Command bus
  output logic lm_o,
  output logic [2:0] bank_o,
  output logic [15:0] addr_o,
  output logic odt_o,
  output logic sr_o,
  output logic dll_rst_o,
  output logic rd_o,
  output logic wr_o
);
  int cyc = 0;
  int ready_at = 0;
  logic dll_off = 1'b1;
  initial begin
    lm_o = 1'b0;
    bank_o = 3'h0;
    addr_o = 16'h0000;
    odt_o = 1'b0;
    sr_o = 1'b0;
    dll_rst_o = 1'b0;
    rd_o = 1'b0;
    wr_o = 1'b0;
  end
  always @(posedge clk_i) cyc <= cyc + 1;
  task automatic dll_reset;
    @(posedge clk_i);
    dll_rst_o <= 1'b1;
    @(posedge clk_i);
    dll_rst_o <= 1'b0;
    ready_at = cyc + 200;
  endtask : dll_reset
  task automatic load_reg(input logic [2:0] b, input logic [15:0] a);
    @(posedge clk_i);
    lm_o <= 1'b1;
    bank_o <= {1'b0, b[1:0]};
    addr_o <= {3'h0, a[12:0]};
    @(posedge clk_i);
    lm_o <= 1'b0;
    // Released bus shows garbage, never the last value
    bank_o <= ~b;
    addr_o <= ~a;
    odt_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    if (b == 3'h1) begin
      if (dll_off && !a[0]) dll_reset();
      dll_off = a[0];
    end
  endtask : load_reg
  task automatic set_odt(input logic v);
    @(posedge clk_i);
    odt_o <= v;
  endtask : set_odt
  // No auto refresh is ever issued, so no precharge-all is owed
  task automatic self_ref(input logic v);
    @(posedge clk_i);
    odt_o <= 1'b0;
    sr_o <= v;
    if (!v) ready_at = cyc + 200;
  endtask : self_ref
  task automatic column(input logic w);
    while (cyc < ready_at) @(posedge clk_i);
    @(posedge clk_i);
    rd_o <= !w;
    wr_o <= w;
    @(posedge clk_i);
    rd_o <= 1'b0;
    wr_o <= 1'b0;
  endtask : column
endmodule : ddr2_ctrl_model
`default_nettype wire

// >>> ddr2_extended_mode_regs.sv
// Behaviour
// - Registers keep contents until rewritten
// - E0 clear enables DLL, E0 set disables it; reset follows enable
// - Self refresh disables DLL, exit relocks it
// - E1 selects full or reduced drive
// - E10 disables strobe complements
// - E11 enables read strobe on by-8 parts only
// - Read strobe on, complement on: both complements
// - E12 disables all data and strobe outputs
// - E2 and E6 select termination value
// - Termination pin honoured in allowed states
// - E3-E5 give additive latency zero to six
// - Posted commands held for additive latency
// - Read latency AL+CL; write latency one less
// - Second register E7 selects fast refresh
// - Bank 1 load writes first register
// - Bank 2 load writes second register
`timescale 1ns/1ns
`default_nettype none
module ddr2_extended_mode_regs (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  // Load mode command
  input wire logic LOAD_MODE_COMMAND_I,
  input wire logic [2:0] BANK_I,
  input wire logic [15:0] ADDR_I,
  // Device state
  input wire logic SELF_REFRESH_I,
  input wire logic ODT_STATE_OK_I,
  input wire logic ODT_I,
  input wire logic DLL_RESET_I,
  input wire logic X8_PART_I,
  input wire logic [2:0] CAS_LATENCY_I,
  // Posted column commands
  input wire logic READ_I,
  input wire logic WRITE_I,
  output logic READ_INTERNAL_O,
  output logic WRITE_INTERNAL_O,
  // Output control
  output logic DLL_ENABLE_O,
  output logic DLL_LOCKED_O,
  output logic DRIVE_REDUCED_O,
  output logic DATA_OUT_EN_O,
  output logic STROBE_OUT_EN_O,
  output logic STROBE_N_OUT_EN_O,
  output logic RDQS_OUT_EN_O,
  output logic RDQS_N_OUT_EN_O,
  output logic [1:0] EFFECTIVE_TERMINATION_VALUE_O,
  output logic TERMINATION_SWITCH_A_O,
  output logic TERMINATION_SWITCH_B_O,
  output logic TERMINATION_SWITCH_C_O,
  output logic [2:0] ADDITIVE_LATENCY_O,
  output logic [emr_pkg::LAT_WIDTH-1:0] READ_LATENCY_O,
  output logic [emr_pkg::LAT_WIDTH-1:0] WRITE_LATENCY_O,
  output logic [2:0] OCD_MODE_O,
  output logic FAST_REFRESH_O
);

  logic [16:0] extended_mode_register_1;
  logic [16:0] extended_mode_register_2;
  logic [16:0] next_emr1;
  logic [16:0] next_extended_mode_register_2;
  logic [16:0] load_word;
  logic load_emr1;
  logic load_extended_mode_register_2;

  emr_pkg::dll_state_e dll_state;
  emr_pkg::dll_state_e next_dll_state;
  logic [7:0] dll_count;
  logic [7:0] next_dll_count;
  logic sr_seen;
  logic [3:0] odt_count;
  logic [3:0] next_odt_count;

  // Termination code {E6,E2} into the three switch legs
  function automatic logic [2:0] rtt_switches(input logic [1:0] code);
    logic [2:0] sw;
    sw = 3'h0;
    unique case (code)
      emr_pkg::RTT_75: sw = 3'h1;
      emr_pkg::RTT_150: sw = 3'h2;
      emr_pkg::RTT_50: sw = 3'h4;
      default: sw = 3'h0;
    endcase
    return sw;
  endfunction : rtt_switches

  function automatic logic [1:0] rtt_code(input logic [16:0] r);
    return {r[emr_pkg::RTT_HI_BIT], r[emr_pkg::RTT_LO_BIT]};
  endfunction : rtt_code

  // Register loads
  always_comb begin
    load_word = {BANK_I[2], ADDR_I};
    load_emr1 = LOAD_MODE_COMMAND_I && (BANK_I == emr_pkg::BANK_EMR1);
    load_extended_mode_register_2 = LOAD_MODE_COMMAND_I && (BANK_I == emr_pkg::BANK_EXTENDED_MODE_REGISTER_2);
    next_emr1 = extended_mode_register_1;
    next_extended_mode_register_2 = extended_mode_register_2;
    if (load_emr1) begin
      next_emr1 = load_word;
    end
    if (load_extended_mode_register_2) begin
      next_extended_mode_register_2 = '0;
      next_extended_mode_register_2[emr_pkg::FAST_REFRESH_BIT] = ADDR_I[emr_pkg::FAST_REFRESH_BIT];
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      extended_mode_register_1 <= emr_pkg::EMR1_RESET;
      extended_mode_register_2 <= emr_pkg::EXTENDED_MODE_REGISTER_2_RESET;
    end else begin
      extended_mode_register_1 <= next_emr1;
      extended_mode_register_2 <= next_extended_mode_register_2;
    end
  end

  // DLL control; a reset after enable restarts the lock count, except while DLL_LOCKING
  always_comb begin
    next_dll_state = dll_state;
    next_dll_count = dll_count;
    if (extended_mode_register_1[emr_pkg::DLL_DIS_BIT] || SELF_REFRESH_I) begin
      next_dll_state = emr_pkg::DLL_OFF;
      next_dll_count = 8'h00;
    end else begin
      unique case (dll_state)
        emr_pkg::DLL_OFF: begin
          if (DLL_RESET_I || sr_seen) begin
            next_dll_state = emr_pkg::DLL_LOCKING;
            next_dll_count = 8'h00;
          end
        end
        emr_pkg::DLL_LOCKING: begin
          next_dll_count = dll_count + 8'h01;
          if (dll_count == 8'(emr_pkg::DLL_LOCK_CYCLES - 1)) begin
            next_dll_state = emr_pkg::DLL_LOCKED;
          end
        end
        emr_pkg::DLL_LOCKED: begin
          if (DLL_RESET_I) begin
            next_dll_state = emr_pkg::DLL_LOCKING;
            next_dll_count = 8'h00;
          end
        end
        default: next_dll_state = emr_pkg::DLL_OFF;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      dll_state <= emr_pkg::DLL_OFF;
      dll_count <= 8'h00;
      sr_seen <= 1'b0;
    end else begin
      dll_state <= next_dll_state;
      dll_count <= next_dll_count;
      sr_seen <= SELF_REFRESH_I;
    end
  end

  // Termination pin is locked out for eight clocks after a first register load
  always_comb begin
    next_odt_count = odt_count;
    if (load_emr1) begin
      next_odt_count = 4'(emr_pkg::ODT_SETTLE_CYCLES);
    end else if (odt_count != 4'h0) begin
      next_odt_count = odt_count - 4'h1;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      odt_count <= 4'h0;
    end else begin
      odt_count <= next_odt_count;
    end
  end

  // Posted column commands
  cmd_delay u_cmd_delay (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .rd_i(READ_I),
    .wr_i(WRITE_I),
    .al_i(extended_mode_register_1[emr_pkg::AL_HI_BIT:emr_pkg::AL_LO_BIT]),
    .rd_o(READ_INTERNAL_O),
    .wr_o(WRITE_INTERNAL_O)
  );

  // Registered output decode
  logic [2:0] al;
  logic out_dis;
  logic rdqs_on;
  logic strobe_n_on;
  logic odt_live;
  logic [2:0] sw;
  logic [3:0] rl;

  always_comb begin
    al = extended_mode_register_1[emr_pkg::AL_HI_BIT:emr_pkg::AL_LO_BIT];
    out_dis = extended_mode_register_1[emr_pkg::OUT_DIS_BIT];
    rdqs_on = extended_mode_register_1[emr_pkg::RDQS_EN_BIT] && X8_PART_I;
    strobe_n_on = !extended_mode_register_1[emr_pkg::STROBE_N_DIS_BIT];
    odt_live = ODT_I && ODT_STATE_OK_I && !SELF_REFRESH_I && (odt_count == 4'h0);
    sw = odt_live ? rtt_switches(rtt_code(extended_mode_register_1)) : 3'h0;
    rl = {1'b0, al} + {1'b0, CAS_LATENCY_I};
  end

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      DLL_ENABLE_O <= 1'b0;
      DLL_LOCKED_O <= 1'b0;
      DRIVE_REDUCED_O <= 1'b0;
      DATA_OUT_EN_O <= 1'b0;
      STROBE_OUT_EN_O <= 1'b0;
      STROBE_N_OUT_EN_O <= 1'b0;
      RDQS_OUT_EN_O <= 1'b0;
      RDQS_N_OUT_EN_O <= 1'b0;
      EFFECTIVE_TERMINATION_VALUE_O <= emr_pkg::RTT_OFF;
      TERMINATION_SWITCH_A_O <= 1'b0;
      TERMINATION_SWITCH_B_O <= 1'b0;
      TERMINATION_SWITCH_C_O <= 1'b0;
      ADDITIVE_LATENCY_O <= 3'h0;
      READ_LATENCY_O <= '0;
      WRITE_LATENCY_O <= '0;
      OCD_MODE_O <= 3'h0;
      FAST_REFRESH_O <= 1'b0;
    end else begin
      DLL_ENABLE_O <= (dll_state != emr_pkg::DLL_OFF);
      DLL_LOCKED_O <= (dll_state == emr_pkg::DLL_LOCKED);
      DRIVE_REDUCED_O <= extended_mode_register_1[emr_pkg::DRV_HALF_BIT];
      DATA_OUT_EN_O <= !out_dis;
      STROBE_OUT_EN_O <= !out_dis;
      STROBE_N_OUT_EN_O <= !out_dis && strobe_n_on;
      RDQS_OUT_EN_O <= !out_dis && rdqs_on;
      RDQS_N_OUT_EN_O <= !out_dis && rdqs_on && strobe_n_on;
      EFFECTIVE_TERMINATION_VALUE_O <= rtt_code(extended_mode_register_1);
      TERMINATION_SWITCH_A_O <= sw[0];
      TERMINATION_SWITCH_B_O <= sw[1];
      TERMINATION_SWITCH_C_O <= sw[2];
      ADDITIVE_LATENCY_O <= al;
      READ_LATENCY_O <= rl;
      WRITE_LATENCY_O <= rl - 4'h1;
      OCD_MODE_O <= extended_mode_register_1[emr_pkg::OCD_HI_BIT:emr_pkg::OCD_LO_BIT];
      FAST_REFRESH_O <= extended_mode_register_2[emr_pkg::FAST_REFRESH_BIT];
    end
  end

  // Checks
  sequence dll_start_s;
    !SELF_REFRESH_I && !extended_mode_register_1[emr_pkg::DLL_DIS_BIT]
      && dll_state == emr_pkg::DLL_OFF && DLL_RESET_I;
  endsequence

  emr1_load_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    load_emr1 |=> extended_mode_register_1 == $past(load_word))
    else $error("first register not loaded");
  extended_mode_register_2_load_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    load_extended_mode_register_2 |=> extended_mode_register_2
      == {9'h000, $past(ADDR_I[emr_pkg::FAST_REFRESH_BIT]), 7'h00})
    else $error("second register load wrong");
  reg_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !LOAD_MODE_COMMAND_I |=> $stable(extended_mode_register_1))
    else $error("register changed without load");
  self_ref_dll_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    SELF_REFRESH_I |=> ##1 !DLL_ENABLE_O)
    else $error("DLL still on in self refresh");
  dll_lock_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    dll_start_s |=> !DLL_LOCKED_O [*8])
    else $error("DLL locked too early");
  odt_settle_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    load_emr1 |=> ##1 !(TERMINATION_SWITCH_A_O || TERMINATION_SWITCH_B_O
      || TERMINATION_SWITCH_C_O) [*8])
    else $error("termination on during settle");
  out_dis_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    extended_mode_register_1[emr_pkg::OUT_DIS_BIT] |=> !DATA_OUT_EN_O && !RDQS_N_OUT_EN_O)
    else $error("outputs not disabled");
  // The first edge after reset still shows the reset values, so skip it
  wl_rl_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !$past(SYS_RST_I) |-> WRITE_LATENCY_O == READ_LATENCY_O - 4'h1)
    else $error("write latency not read latency minus one");
  al_zero_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (READ_I && extended_mode_register_1[emr_pkg::AL_HI_BIT:emr_pkg::AL_LO_BIT] == 3'h0)
      |=> READ_INTERNAL_O)
    else $error("read not released at zero latency");
  term_gate_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (!ODT_I || !ODT_STATE_OK_I || SELF_REFRESH_I) |=> !(TERMINATION_SWITCH_A_O
      || TERMINATION_SWITCH_B_O || TERMINATION_SWITCH_C_O))
    else $error("termination on while its pin is not honoured");
  rdqs_x8_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !X8_PART_I |=> !RDQS_OUT_EN_O && !RDQS_N_OUT_EN_O)
    else $error("read strobe driven on a part that is not by-8");
  drive_sel_a: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !$past(SYS_RST_I) |-> DRIVE_REDUCED_O
      == $past(extended_mode_register_1[emr_pkg::DRV_HALF_BIT]))
    else $error("drive strength does not follow its bit");
endmodule : ddr2_extended_mode_regs
`default_nettype wire

// >>> ddr2_extended_mode_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module ddr2_extended_mode_regs_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic state_ok = 1'b0;
  logic x8 = 1'b0;
  logic [2:0] cl = 3'h0;
  logic lm, odt, sr, dll_rst, rd, wr, rd_int, wr_int, fast;
  logic dll_en, dll_lock, drv, dq_en, s_en, sn_en, r_en, rn_en, sw_a, sw_b, sw_c;
  logic [2:0] bank, al, ocd;
  logic [15:0] addr;
  logic [1:0] rtt;
  logic [3:0] rl, wl;
  logic [2:0] swx [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
  logic [15:0] oa [7] = '{16'h0000, 16'h0002, 16'h0400, 16'h0800, 16'h0C00, 16'h0800, 16'h1800};
  logic ox [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic [5:0] oe [7] = '{6'h1C, 6'h3C, 6'h18, 6'h1F, 6'h1A, 6'h1C, 6'h00};
  int n_fail = 0;
  int n_checks = 0;
  always #4 clk = ~clk;
  ddr2_ctrl_model ctrl_u (.clk_i(clk), .lm_o(lm), .bank_o(bank), .addr_o(addr), .odt_o(odt),
    .sr_o(sr), .dll_rst_o(dll_rst), .rd_o(rd), .wr_o(wr));
  ddr2_extended_mode_regs dut_u (.SYS_CLK_I(clk), .SYS_RST_I(rst), .LOAD_MODE_COMMAND_I(lm),
    .BANK_I(bank), .ADDR_I(addr), .SELF_REFRESH_I(sr), .ODT_STATE_OK_I(state_ok), .ODT_I(odt),
    .DLL_RESET_I(dll_rst), .X8_PART_I(x8), .CAS_LATENCY_I(cl), .READ_I(rd), .WRITE_I(wr),
    .READ_INTERNAL_O(rd_int), .WRITE_INTERNAL_O(wr_int), .DLL_ENABLE_O(dll_en),
    .DLL_LOCKED_O(dll_lock), .DRIVE_REDUCED_O(drv), .DATA_OUT_EN_O(dq_en),
    .STROBE_OUT_EN_O(s_en), .STROBE_N_OUT_EN_O(sn_en), .RDQS_OUT_EN_O(r_en),
    .RDQS_N_OUT_EN_O(rn_en), .EFFECTIVE_TERMINATION_VALUE_O(rtt),
    .TERMINATION_SWITCH_A_O(sw_a), .TERMINATION_SWITCH_B_O(sw_b),
    .TERMINATION_SWITCH_C_O(sw_c), .ADDITIVE_LATENCY_O(al), .READ_LATENCY_O(rl),
    .WRITE_LATENCY_O(wl), .OCD_MODE_O(ocd), .FAST_REFRESH_O(fast));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  // Counts edges from the taking edge until the internal strobe is sampled high
  task automatic col_lat(input logic w, input int exp);
    int k;
    ctrl_u.column(w);
    for (k = 1; k < 12; k++) begin
      #1;
      if ((w ? wr_int : rd_int) === 1'b1) break;
      @(posedge clk);
    end
    chk(16'(k), 16'(exp));
  endtask : col_lat
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  initial begin
    #80000;
    n_fail++;
    complete_run();
  end
  initial begin
    int c;
    settle(7);
    chk({5'h00, dll_en, dll_lock, fast, rtt, al, ocd}, 16'h0000);
    @(posedge clk);
    rst <= 1'b0;
    state_ok <= 1'b1;
    x8 <= 1'b1;
    cl <= 3'h3;
    ctrl_u.load_reg(3'h1, 16'h0000);
    settle(150);
    chk({15'h0, dll_lock}, 16'h0000);
    settle(60);
    chk({14'h0, dll_en, dll_lock}, 16'h0003);
    ctrl_u.self_ref(1'b1);
    settle(4);
    chk({15'h0, dll_lock}, 16'h0000);
    ctrl_u.self_ref(1'b0);
    settle(210);
    chk({15'h0, dll_lock}, 16'h0001);
    ctrl_u.load_reg(3'h1, 16'h0001);
    settle(1);
    chk({15'h0, dll_en}, 16'h0000);
    $display("dll test done");
    for (c = 0; c < 7; c++) begin
      ctrl_u.load_reg(3'h1, 16'(c << 3));
      settle(1);
      chk({13'h0, al}, 16'(c));
      chk({4'h0, rl, 4'h0, wl}, 16'((c + 3) << 8 | (c + 2)));
      col_lat(1'b0, c + 1);
      col_lat(1'b1, c + 1);
    end
    $display("latency test done");
    for (c = 0; c < 4; c++) begin
      ctrl_u.load_reg(3'h1, {9'h0, c[1], 3'h0, c[0], 2'h0});
      settle(1);
      chk({14'h0, rtt}, 16'(c));
      ctrl_u.set_odt(1'b1);
      settle(3);
      chk({13'h0, sw_a, sw_b, sw_c}, {13'h0, swx[c]});
      @(posedge clk);
      state_ok <= 1'b0;
      settle(3);
      chk({13'h0, sw_a, sw_b, sw_c}, 16'h0000);
      @(posedge clk);
      state_ok <= 1'b1;
      ctrl_u.set_odt(1'b0);
    end
    $display("termination test done");
    for (c = 0; c < 7; c++) begin
      @(posedge clk);
      x8 <= ox[c];
      ctrl_u.load_reg(3'h1, oa[c]);
      settle(1);
      chk({10'h0, drv, dq_en, s_en, sn_en, r_en, rn_en}, {10'h0, oe[c]});
    end
    $display("output test done");
    ctrl_u.load_reg(3'h1, 16'h0380);
    settle(1);
    chk({13'h0, ocd}, 16'h0007);
    ctrl_u.load_reg(3'h1, 16'h0000);
    ctrl_u.load_reg(3'h3, 16'h0044);
    ctrl_u.load_reg(3'h0, 16'h0044);
    settle(1);
    chk({11'h0, rtt, ocd}, 16'h0000);
    ctrl_u.load_reg(3'h2, 16'h0080);
    settle(1);
    chk({15'h0, fast}, 16'h0001);
    chk({13'h0, al}, 16'h0000);
    $display("register select test done");
    complete_run();
  end
endmodule : ddr2_extended_mode_regs_tb_top
`default_nettype wire

// >>> emr_pkg.sv
package emr_pkg;
  // Bit positions of the first extended register
  localparam int DLL_DIS_BIT = 0;
  localparam int DRV_HALF_BIT = 1;
  localparam int RTT_LO_BIT = 2;
  localparam int AL_LO_BIT = 3;
  localparam int AL_HI_BIT = 5;
  localparam int RTT_HI_BIT = 6;
  localparam int OCD_LO_BIT = 7;
  localparam int OCD_HI_BIT = 9;
  localparam int STROBE_N_DIS_BIT = 10;
  localparam int RDQS_EN_BIT = 11;
  localparam int OUT_DIS_BIT = 12;
  // Second extended register
  localparam int FAST_REFRESH_BIT = 7;
  localparam int REG_WIDTH = 17;
  localparam int ADDR_WIDTH = 16;
  // Bank address selects
  localparam logic [2:0] BANK_EMR1 = 3'h1;
  localparam logic [2:0] BANK_EXTENDED_MODE_REGISTER_2 = 3'h2;
  // Reset values: DLL on, full drive, no termination, AL 0
  localparam logic [16:0] EMR1_RESET = 17'h00000;
  localparam logic [16:0] EXTENDED_MODE_REGISTER_2_RESET = 17'h00000;
  // Termination codes {E6,E2}
  localparam logic [1:0] RTT_OFF = 2'h0;
  localparam logic [1:0] RTT_75 = 2'h1;
  localparam logic [1:0] RTT_150 = 2'h2;
  localparam logic [1:0] RTT_50 = 2'h3;
  localparam logic [2:0] AL_MAX = 3'h6;
  // DLL lock and termination settle, in clocks
  localparam int DLL_LOCK_CYCLES = 200;
  localparam int ODT_SETTLE_CYCLES = 8;
  localparam int LAT_WIDTH = 4;
  localparam int AL_DEPTH = 8;
  typedef enum logic [1:0] {
    DLL_OFF = 2'b00,
    DLL_LOCKING = 2'b01,
    DLL_LOCKED = 2'b11
  } dll_state_e;
endpackage : emr_pkg
